/* design/csr_regs.sv */
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - main_control bit 0 selects protected mode; clear means real-mode addressing
// - WAIT faults 7 when wait_monitor_fpu and task_switched_flag both set
// - fpu_soft_trap makes every fpu opcode fault 7; WAIT unaffected alone
// - Hardware sets task_switched_flag on task switch; fpu opcodes then fault
// - fpu_fault_internal routes fpu errors to vector 16, else external signalling
// - supervisor_write_guard makes read-only page writes fault at every privilege
// - Alignment faults need both align_check_mask and align_check_flag
// - cache_write_through set: every write, hits included, goes to the bus
// - cache_write_through clear: bus writes only on miss, dirty replacement, inquiry
// - cache_fill_off stops line fills; hits, write updates, inquiries continue
// - Paging active with paging_on and protected mode, after a branch
// - fault_address captures the page-fault linear address, latest fault wins
// - page_dir_base holds upper 20 bits plus PCD bit 4 and PWT bit 3; other low bits stay zero
// - Unpaged cycles drive page_uncached and page_write_thru onto pins
// - stamp_read_priv limits timestamp reads to privilege 0
// - io_break_ext selects breakpoint decode with I/O type
// - global_page_on keeps global TLB entries across switches and base writes
// - perf_count_user allows perf counter reads at any privilege
// - Low 16 bits of main_control alias as machine_status_word
// - align_check_flag in flags register enables alignment faults
module csr_regs
  import csr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic msw_sel,
  output logic [31:0] reg_rdata,
  input wire logic task_switch,
  input wire logic page_fault,
  input wire logic [31:0] fault_linear_addr,
  input wire logic branch_taken,
  input wire logic [31:0] flags_register,
  input wire logic [1:0] current_privilege,
  input wire logic is_wait,
  input wire logic is_fpu_opcode,
  input wire logic is_stamp_read,
  input wire logic is_perf_read,
  input wire logic fpu_error,
  input wire logic page_write,
  input wire logic page_read_only,
  input wire logic mem_misaligned,
  input wire logic cache_write,
  input wire logic cache_hit,
  input wire logic dirty_replace,
  input wire logic inquiry,
  input wire logic cache_miss,
  input wire logic paged_cycle,
  input wire logic bus_cycle,
  input wire logic [1:0] brk_type,
  output logic protected_mode_on,
  output logic paging_active,
  output logic fault_fpu_unavail,
  output logic fault_priv,
  output logic fpu_vec_valid,
  output logic [7:0] fpu_vec,
  output logic fpu_error_ext,
  output logic fault_write_protect,
  output logic fault_align,
  output logic bus_write_req,
  output logic fill_allow,
  output logic page_uncached,
  output logic page_write_thru,
  output logic [31:0] tlb_flush_nonglobal_only,
  output logic brk_exec,
  output logic brk_write,
  output logic brk_io,
  output logic brk_read_write,
  output logic handler_ready
);
  logic rst_s1, rst_sync;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sync <= rst_s1;
    end
  end

  logic [31:0] main_control, fault_address, page_dir_base, extension_control;
  logic [31:0] next_main_control, next_fault_address, next_page_dir_base, next_extension_control;
  logic paging_pending, next_paging_pending;
  logic paging_eff, next_paging_eff;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction : merge

  always_comb begin
    next_main_control = main_control;
    next_fault_address = fault_address;
    next_page_dir_base = page_dir_base;
    next_extension_control = extension_control;
    next_paging_pending = paging_pending;
    next_paging_eff = paging_eff;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_MAIN: begin
          // Fixed bit kept by the write mask, not by trust in software
          if (msw_sel) begin
            next_main_control = merge(main_control, reg_wdata, MAIN_WMASK & 32'h0000FFFF);
          end else begin
            next_main_control = merge(main_control, reg_wdata, MAIN_WMASK);
          end
        end
        ADDR_FAULT: next_fault_address = reg_wdata;
        ADDR_PDIR: next_page_dir_base = merge(page_dir_base, reg_wdata, PDIR_WMASK);
        ADDR_EXT: next_extension_control = merge(extension_control, reg_wdata, EXT_WMASK);
      endcase
    end
    if (next_main_control[B_PAGING] != main_control[B_PAGING]) begin
      next_paging_pending = 1'b1;
    end
    // Paging change waits for the branch that follows it
    if (branch_taken && paging_pending) begin
      next_paging_eff = main_control[B_PAGING];
      next_paging_pending = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    if (task_switch) begin
      next_main_control[B_TASKSW] = 1'b1;
    end
    if (page_fault && paging_active) begin
      next_fault_address = fault_linear_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      main_control <= MAIN_RESET;
      fault_address <= ZERO_RESET;
      page_dir_base <= ZERO_RESET;
      extension_control <= ZERO_RESET;
      paging_pending <= 1'b0;
      paging_eff <= 1'b0;
    end else if (clk_en) begin
      main_control <= next_main_control;
      fault_address <= next_fault_address;
      page_dir_base <= next_page_dir_base;
      extension_control <= next_extension_control;
      paging_pending <= next_paging_pending;
      paging_eff <= next_paging_eff;
    end
  end

  logic dec_fpu, dec_priv;
  csr_fault_decode csr_fault_decode_i (
    .main_control(main_control),
    .extension_control(extension_control),
    .is_wait(is_wait),
    .is_fpu_opcode(is_fpu_opcode),
    .is_stamp_read(is_stamp_read),
    .is_perf_read(is_perf_read),
    .current_privilege(current_privilege),
    .fault_fpu_unavail(dec_fpu),
    .fault_priv(dec_priv)
  );

  logic [31:0] next_rdata;
  logic n_pm, n_pa, n_fvv, n_fext, n_wp, n_al, n_bw, n_fa, n_pcd, n_pwt;
  logic [7:0] n_fvec;
  logic [31:0] n_tlb;
  logic n_be, n_bwr, n_bio, n_brw, n_hr;
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_MAIN: next_rdata = msw_sel ? {16'h0000, main_control[15:0]} : main_control;
        ADDR_FAULT: next_rdata = fault_address;
        ADDR_PDIR: next_rdata = page_dir_base;
        ADDR_EXT: next_rdata = extension_control;
      endcase
    end
    n_pm = main_control[B_PROT];
    n_pa = paging_eff & main_control[B_PROT];
    n_fvv = fpu_error & main_control[B_FPUINT];
    n_fvec = main_control[B_FPUINT] ? VEC_FPU_ERROR : VEC_FPU_UNAVAIL;
    n_fext = fpu_error & ~main_control[B_FPUINT];
    n_wp = page_write & page_read_only & (main_control[B_WGUARD] | (current_privilege == 2'h3));
    n_al = mem_misaligned & main_control[B_ALIGNM] & flags_register[B_FLAG_AC];
    n_bw = main_control[B_WTHRU] ? cache_write : ((cache_write & cache_miss) | dirty_replace | inquiry);
    n_fa = cache_miss & ~main_control[B_FILLOFF];
    n_pcd = page_uncached;
    n_pwt = page_write_thru;
    if (bus_cycle && (!paged_cycle || !n_pa)) begin
      n_pcd = page_dir_base[B_PCD];
      n_pwt = page_dir_base[B_PWT];
    end
    // Bit set: flush non-global entries only on switch or base write
    n_tlb = {31'h00000000, extension_control[B_GLOBAL] & (task_switch | (reg_wr & reg_addr == ADDR_PDIR))};
    n_be = extension_control[B_IOBRK] ? (brk_type == BRK_EXEC) : (brk_type == BRK_EXEC);
    n_bwr = brk_type == BRK_WRITE;
    n_bio = extension_control[B_IOBRK] & (brk_type == BRK_IO);
    n_brw = brk_type == BRK_RW;
    n_hr = ~(page_fault & paging_active);
  end

  always_ff @(posedge ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata <= ZERO_RESET;
      protected_mode_on <= 1'b0;
      paging_active <= 1'b0;
      fault_fpu_unavail <= 1'b0;
      fault_priv <= 1'b0;
      fpu_vec_valid <= 1'b0;
      fpu_vec <= VEC_FPU_UNAVAIL;
      fpu_error_ext <= 1'b0;
      fault_write_protect <= 1'b0;
      fault_align <= 1'b0;
      bus_write_req <= 1'b0;
      fill_allow <= 1'b0;
      page_uncached <= 1'b0;
      page_write_thru <= 1'b0;
      tlb_flush_nonglobal_only <= ZERO_RESET;
      brk_exec <= 1'b0;
      brk_write <= 1'b0;
      brk_io <= 1'b0;
      brk_read_write <= 1'b0;
      handler_ready <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
      protected_mode_on <= n_pm;
      paging_active <= n_pa;
      fault_fpu_unavail <= dec_fpu;
      fault_priv <= dec_priv;
      fpu_vec_valid <= n_fvv;
      fpu_vec <= n_fvec;
      fpu_error_ext <= n_fext;
      fault_write_protect <= n_wp;
      fault_align <= n_al;
      bus_write_req <= n_bw;
      fill_allow <= n_fa;
      page_uncached <= n_pcd;
      page_write_thru <= n_pwt;
      tlb_flush_nonglobal_only <= n_tlb;
      brk_exec <= n_be;
      brk_write <= n_bwr;
      brk_io <= n_bio;
      brk_read_write <= n_brw;
      handler_ready <= n_hr;
    end
  end

  AST_TS_SET: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (task_switch && clk_en) |=> main_control[B_TASKSW]) else $error("task switch flag not set");
  AST_FIXED_BIT: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    main_control[B_FIXED]) else $error("fixed bit changed");
  AST_FAULT_CAP: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (page_fault && paging_active && clk_en) |=> fault_address == $past(fault_linear_addr)) else $error("fault address");
  AST_ALIGN: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (clk_en && !main_control[B_ALIGNM]) |=> !fault_align) else $error("align fault while masked");
  AST_PAGING: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    paging_active |-> $past(main_control[B_PROT])) else $error("paging without protection");
  AST_FILL: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (clk_en && main_control[B_FILLOFF]) |=> !fill_allow) else $error("fill while off");
  AST_WTHRU: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (clk_en && main_control[B_WTHRU] && cache_write) |=> bus_write_req) else $error("write-through missed");
  AST_FPU7: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (clk_en && is_fpu_opcode && main_control[B_SOFTTRAP]) |=> fault_fpu_unavail) else $error("soft trap missed");
  AST_STAMP: assert property (@(posedge ref_clk) disable iff (!rst_sync)
    (clk_en && is_stamp_read && extension_control[B_STAMP] && current_privilege != 2'h0) |=> fault_priv)
    else $error("stamp read not blocked");
endmodule : csr_regs

/* include/csr_pkg.sv */
package csr_pkg;
  localparam logic [1:0] ADDR_MAIN = 2'h0;
  localparam logic [1:0] ADDR_FAULT = 2'h1;
  localparam logic [1:0] ADDR_PDIR = 2'h2;
  localparam logic [1:0] ADDR_EXT = 2'h3;
  localparam int B_PROT = 0;
  localparam int B_WAITMON = 1;
  localparam int B_SOFTTRAP = 2;
  localparam int B_TASKSW = 3;
  localparam int B_FIXED = 4;
  localparam int B_FPUINT = 5;
  localparam int B_WGUARD = 16;
  localparam int B_ALIGNM = 18;
  localparam int B_WTHRU = 29;
  localparam int B_FILLOFF = 30;
  localparam int B_PAGING = 31;
  localparam int B_PWT = 3;
  localparam int B_PCD = 4;
  localparam int B_STAMP = 2;
  localparam int B_IOBRK = 3;
  localparam int B_GLOBAL = 7;
  localparam int B_PERF = 8;
  localparam int B_FLAG_AC = 18;
  localparam logic [31:0] MAIN_WMASK = 32'hE005002F;
  localparam logic [31:0] MAIN_RESET = 32'h00000010;
  localparam logic [31:0] PDIR_WMASK = 32'hFFFFF018;
  localparam logic [31:0] EXT_WMASK = 32'h0000018C;
  localparam logic [31:0] ZERO_RESET = 32'h00000000;
  localparam logic [7:0] VEC_FPU_UNAVAIL = 8'h07;
  localparam logic [7:0] VEC_FPU_ERROR = 8'h10;
  localparam logic [1:0] BRK_EXEC = 2'h0;
  localparam logic [1:0] BRK_WRITE = 2'h1;
  localparam logic [1:0] BRK_IO = 2'h2;
  localparam logic [1:0] BRK_RW = 2'h3;
endpackage : csr_pkg

/* design/csr_fault_decode.sv */
`timescale 1ns/1ps
module csr_fault_decode
  import csr_pkg::*;
(
  input wire logic [31:0] main_control,
  input wire logic [31:0] extension_control,
  input wire logic is_wait,
  input wire logic is_fpu_opcode,
  input wire logic is_stamp_read,
  input wire logic is_perf_read,
  input wire logic [1:0] current_privilege,
  output logic fault_fpu_unavail,
  output logic fault_priv
);
  always_comb begin
    fault_fpu_unavail = (is_wait & main_control[B_WAITMON] & main_control[B_TASKSW]) |
      (is_fpu_opcode & (main_control[B_SOFTTRAP] | main_control[B_TASKSW]));
    fault_priv = (is_stamp_read & extension_control[B_STAMP] & (current_privilege != 2'h0)) |
      (is_perf_read & ~extension_control[B_PERF] & (current_privilege != 2'h0));
  end
endmodule : csr_fault_decode

/* verif/tb_csr_regs.sv */
`timescale 1ns/1ps
module tb_csr_regs
  import csr_pkg::*;
;
  logic ref_clk, rst_b, clk_en, reg_wr, reg_rd, msw_sel, task_switch, page_fault, branch_taken;
  logic is_wait, is_fpu_opcode, is_stamp_read, is_perf_read, fpu_error, page_write, page_read_only;
  logic mem_misaligned, cache_write, cache_hit, dirty_replace, inquiry, cache_miss, paged_cycle, bus_cycle;
  logic protected_mode_on, paging_active, fault_fpu_unavail, fault_priv, fpu_vec_valid, fpu_error_ext;
  logic fault_write_protect, fault_align, bus_write_req, fill_allow, page_uncached, page_write_thru;
  logic brk_exec, brk_write, brk_io, brk_read_write, handler_ready;
  logic [1:0] reg_addr, current_privilege, brk_type;
  logic [31:0] reg_wdata, reg_rdata, fault_linear_addr, flags_register, tlb_flush_nonglobal_only, v;
  logic [7:0] fpu_vec;
  int n_fail, checked, i;

  csr_regs csr_regs_i (.*);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task chkb(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chkb

  task wr(input logic [1:0] a, input logic [31:0] d, input logic m);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    msw_sel <= m;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    msw_sel <= 1'b0;
  endtask : wr

  task rd(input logic [1:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  // Outputs land one edge after their cause
  task tk;
    @(posedge ref_clk);
    #1;
  endtask : tk

  task clr;
    {task_switch, page_fault, branch_taken, is_wait, is_fpu_opcode, is_stamp_read} <= 6'h00;
    {is_perf_read, fpu_error, page_write, page_read_only, mem_misaligned, cache_write} <= 6'h00;
    {cache_hit, cache_miss, paged_cycle, bus_cycle} <= 4'h0;
  endtask : clr

  task end_of_test;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  initial begin
    #(25 * 20000);
    n_fail++;
    end_of_test;
  end

  initial begin
    {n_fail, checked, rst_b, reg_wr, reg_rd, msw_sel, reg_addr, reg_wdata} = '0;
    {fault_linear_addr, flags_register, current_privilege, brk_type, dirty_replace, inquiry} = '0;
    clk_en = 1'b1;
    clr;
    repeat (3) @(posedge ref_clk);
    chk({24'h0, fpu_vec}, {24'h0, VEC_FPU_UNAVAIL});
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(ADDR_MAIN, MAIN_RESET);
    rd(ADDR_FAULT, ZERO_RESET);
    rd(ADDR_PDIR, ZERO_RESET);
    rd(ADDR_EXT, ZERO_RESET);
    wr(ADDR_MAIN, 32'hFFFFFFFF, 1'b0);
    rd(ADDR_MAIN, MAIN_WMASK | MAIN_RESET);
    wr(ADDR_MAIN, 32'h00000000, 1'b1);
    rd(ADDR_MAIN, 32'hE0050010);
    wr(ADDR_PDIR, 32'hFFFFFFFF, 1'b0);
    rd(ADDR_PDIR, PDIR_WMASK);
    wr(ADDR_EXT, 32'hFFFFFFFF, 1'b0);
    rd(ADDR_EXT, EXT_WMASK);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      wr(ADDR_MAIN, {28'h0, i[1], i[2], i[0], 1'b0}, 1'b0);
      @(posedge ref_clk);
      is_wait <= 1'b1;
      tk;
      chkb(fault_fpu_unavail, i[1] & i[0]);
      clr;
      @(posedge ref_clk);
      is_fpu_opcode <= 1'b1;
      tk;
      chkb(fault_fpu_unavail, i[2] | i[1]);
      clr;
    end
    for (i = 0; i < 2; i++) begin
      wr(ADDR_EXT, {24'h0, i[0], 7'h0}, 1'b0);
      wr(ADDR_MAIN, 32'h00000000, 1'b0);
      @(posedge ref_clk);
      task_switch <= 1'b1;
      tk;
      chkb(tlb_flush_nonglobal_only[0], i[0]);
      clr;
      rd(ADDR_MAIN, 32'h00000018);
    end
    for (i = 0; i < 2; i++) begin
      wr(ADDR_MAIN, {26'h0, i[0], 5'h0}, 1'b0);
      @(posedge ref_clk);
      fpu_error <= 1'b1;
      tk;
      chkb(fpu_vec_valid, i[0]);
      chkb(fpu_error_ext, !i[0]);
      if (i[0]) chk({24'h0, fpu_vec}, {24'h0, VEC_FPU_ERROR});
      clr;
    end
    $display("test fpu done");
    for (i = 0; i < 4; i++) begin
      wr(ADDR_MAIN, {13'h0, i[1], 1'b0, i[1], 16'h0}, 1'b0);
      @(posedge ref_clk);
      {page_write, page_read_only, mem_misaligned} <= 3'h7;
      current_privilege <= i[0] ? 2'h3 : 2'h1;
      flags_register <= {13'h0, i[0], 18'h0};
      tk;
      chkb(fault_write_protect, i[1] | i[0]);
      chkb(fault_align, i[1] & i[0]);
      clr;
    end
    $display("test protection done");
    for (i = 0; i < 4; i++) begin
      wr(ADDR_MAIN, {1'b0, i[1], i[0], 29'h0}, 1'b0);
      @(posedge ref_clk);
      {cache_write, cache_hit} <= 2'h3;
      tk;
      chkb(bus_write_req, i[0]);
      clr;
      @(posedge ref_clk);
      {cache_write, cache_miss} <= 2'h3;
      tk;
      chkb(bus_write_req, 1'b1);
      clr;
      @(posedge ref_clk);
      cache_miss <= 1'b1;
      tk;
      chkb(fill_allow, !i[1]);
      clr;
    end
    $display("test cache done");
    for (i = 0; i < 2; i++) begin
      // Protected first: a second pass would see paging already in force
      wr(ADDR_MAIN, {1'b1, 30'h0, !i[0]}, 1'b0);
      tk;
      chkb(protected_mode_on, !i[0]);
      chkb(paging_active, 1'b0);
      @(posedge ref_clk);
      branch_taken <= 1'b1;
      tk;
      clr;
      tk;
      tk;
      chkb(paging_active, !i[0]);
    end
    wr(ADDR_MAIN, 32'h80000001, 1'b0);
    tk;
    chkb(paging_active, 1'b1);
    @(posedge ref_clk);
    page_fault <= 1'b1;
    fault_linear_addr <= 32'hA5A51234;
    @(posedge ref_clk);
    fault_linear_addr <= 32'h5A5AEDCB;
    tk;
    chkb(handler_ready, 1'b0);
    clr;
    rd(ADDR_FAULT, 32'h5A5AEDCB);
    clk_en <= 1'b0;
    wr(ADDR_FAULT, 32'h12345678, 1'b0);
    clk_en <= 1'b1;
    rd(ADDR_FAULT, 32'h5A5AEDCB);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_PDIR, {20'h12345, 7'h0, i[1], i[0], 3'h0}, 1'b0);
      @(posedge ref_clk);
      bus_cycle <= 1'b1;
      tk;
      chkb(page_uncached, i[1]);
      chkb(page_write_thru, i[0]);
      clr;
    end
    $display("test paging done");
    for (i = 0; i < 4; i++) begin
      wr(ADDR_EXT, {23'h0, i[1], 5'h0, i[0], 2'h0}, 1'b0);
      @(posedge ref_clk);
      current_privilege <= 2'h3;
      is_stamp_read <= 1'b1;
      tk;
      chkb(fault_priv, i[0]);
      clr;
      @(posedge ref_clk);
      is_perf_read <= 1'b1;
      tk;
      chkb(fault_priv, !i[1]);
      clr;
      @(posedge ref_clk);
      current_privilege <= 2'h0;
      {is_stamp_read, is_perf_read} <= 2'h3;
      tk;
      chkb(fault_priv, 1'b0);
      clr;
    end
    for (i = 0; i < 8; i++) begin
      wr(ADDR_EXT, {28'h0, i[2], 3'h0}, 1'b0);
      @(posedge ref_clk);
      brk_type <= i[1:0];
      tk;
      v = 32'h1 << i[1:0];
      if (!i[2]) v[2] = 1'b0;
      chk({28'h0, brk_read_write, brk_io, brk_write, brk_exec}, v);
    end
    $display("test privilege and breakpoints done");
    end_of_test;
  end
endmodule : tb_csr_regs
